// ---- hw/tsec_params.svh ----
// Constants of the two-stage event controller
`ifndef TSEC_PARAMS_SVH
`define TSEC_PARAMS_SVH

// ----------------------------------------------------------------
// Event numbers, lower number wins
// ----------------------------------------------------------------
`define TSEC_EVT_W 4
`define TSEC_NUM_EVT 16
`define TSEC_EVT_EMU 4'h0
`define TSEC_EVT_RST 4'h1
`define TSEC_EVT_NMI 4'h2
`define TSEC_EVT_EXC 4'h3
`define TSEC_GP_FIRST 4'h7
`define TSEC_GP_LAST 4'hf
`define TSEC_SW_FIRST 4'he
`define TSEC_NONE 5'h10

// ----------------------------------------------------------------
// Widths, counts and reset values
// ----------------------------------------------------------------
`define TSEC_PC_W 32
`define TSEC_PERIPH_N 16
`define TSEC_LVL_FLD_W 3
`define TSEC_PERIPH_LVL_MAX 3'h6
`define TSEC_RST_HOLD 4'h4
`define TSEC_ZERO_MAP 16'h0000

`endif

// ---- hw/tsec_pkg.sv ----
// Types shared by the event controller modules
`include "tsec_params.svh"
package tsec_pkg;
  typedef logic [`TSEC_EVT_W-1:0] tsec_evt_t;
  typedef logic [`TSEC_NUM_EVT-1:0] tsec_map_t;
  typedef logic [`TSEC_PC_W-1:0] tsec_addr_t;
  typedef enum logic {TSEC_EXC_ALIGN, TSEC_EXC_UNDEF} tsec_exc_t;
  typedef enum logic [1:0] {TSEC_ST_RUN, TSEC_ST_RESET, TSEC_ST_CLEAR} tsec_state_t;

  // Lowest set index, or TSEC_NONE when empty
  function automatic logic [4:0] tsec_lowest(input tsec_map_t m);
    logic [4:0] r;
    r = `TSEC_NONE;
    for (int i = `TSEC_NUM_EVT - 1; i >= 0; i--) begin
      if (m[i]) begin
        r = 5'(i);
      end
    end
    return r;
  endfunction
endpackage

// ---- hw/tsec_core_if.sv ----
// Carrier between core stage, system stage and return-address bank
`timescale 1ns/1ps
interface tsec_core_if;
  import tsec_pkg::*;
  tsec_map_t gp_req;
  logic wr_en;
  tsec_evt_t wr_idx;
  tsec_addr_t wr_addr;
  tsec_evt_t rd_idx;
  tsec_addr_t rd_addr;
  modport sic_mp (output gp_req);
  modport bank_mp (input wr_en, input wr_idx, input wr_addr, input rd_idx, output rd_addr);
  modport core_mp (input gp_req, input rd_addr, output wr_en, output wr_idx, output wr_addr, output rd_idx);
endinterface

// ---- hw/tsec_sic.sv ----
// System interrupt stage: routes peripheral requests onto core levels
`timescale 1ns/1ps
`include "tsec_params.svh"
module tsec_sic #(
  parameter int PERIPH_N = `TSEC_PERIPH_N
) (
  input wire logic clk_i, // Core clock
  input wire logic reset_i, // Sync reset
  input wire logic ce_i, // Clock enable
  input wire logic [PERIPH_N-1:0] req_i, // Peripheral requests
  input wire logic [PERIPH_N-1:0] enable_i, // Per-source enables
  input wire logic [PERIPH_N*`TSEC_LVL_FLD_W-1:0] level_i, // Level offset per source
  tsec_core_if.sic_mp core // Routed requests
);
  import tsec_pkg::*;

  tsec_map_t gp_reg;
  tsec_map_t gp_next;

  // Route each enabled source to level 7 plus its offset; offsets above 6 drop
  always_comb begin
    gp_next = `TSEC_ZERO_MAP;
    for (int p = 0; p < PERIPH_N; p++) begin
      if (req_i[p] && enable_i[p] &&
          level_i[p*`TSEC_LVL_FLD_W +: `TSEC_LVL_FLD_W] <= `TSEC_PERIPH_LVL_MAX) begin
        gp_next[`TSEC_GP_FIRST + {1'b0, level_i[p*`TSEC_LVL_FLD_W +: `TSEC_LVL_FLD_W]}] = 1'b1;
      end
    end
  end

  // One register stage toward the core
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      gp_reg <= `TSEC_ZERO_MAP;
    end else if (ce_i) begin
      gp_reg <= gp_next;
    end
  end

  assign core.gp_req = gp_reg;
endmodule // tsec_sic

// ---- hw/tsec_retbank.sv ----
// One return-address register per event number
`timescale 1ns/1ps
`include "tsec_params.svh"
module tsec_retbank (
  input wire logic clk_i, // Core clock
  input wire logic reset_i, // Sync reset
  input wire logic ce_i, // Clock enable
  tsec_core_if.bank_mp core // Write on take, read on return
);
  import tsec_pkg::*;

  tsec_addr_t addr_reg [`TSEC_NUM_EVT];

  // Load the interrupted address of the event just taken
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      for (int i = 0; i < `TSEC_NUM_EVT; i++) begin
        addr_reg[i] <= '0;
      end
    end else if (ce_i && core.wr_en) begin
      addr_reg[core.wr_idx] <= core.wr_addr;
    end
  end

  assign core.rd_addr = addr_reg[core.rd_idx];
endmodule // tsec_retbank

// ---- hw/tsec_top.sv ----
// Core event stage with dispatch toward the core sequencer
`timescale 1ns/1ps
`include "tsec_params.svh"
module tsec_top #(
  parameter int PERIPH_N = `TSEC_PERIPH_N,
  parameter logic [3:0] RST_HOLD = `TSEC_RST_HOLD
) (
  input wire logic CLK_I, // Core clock, 250 MHz
  input wire logic RESET_I, // Sync reset, active high
  input wire logic CE_I, // Freezes all state when low
  input wire logic EMU_REQ_I, // Emulation request
  input wire logic RESET_REQ_I, // Reset event request
  input wire logic NMI_PIN_I, // Non-maskable pin
  input wire logic WDOG_NMI_I, // Watchdog non-maskable request
  input wire logic EXC_REQ_I, // Exception from sequencer
  input wire tsec_pkg::tsec_exc_t EXC_CAUSE_I, // Exception cause
  input wire logic [PERIPH_N-1:0] PERIPH_REQ_I, // Peripheral requests
  input wire logic [PERIPH_N-1:0] PERIPH_EN_I, // Peripheral enables
  input wire logic [PERIPH_N*`TSEC_LVL_FLD_W-1:0] PERIPH_LVL_I, // Level offset per source
  input wire logic SW_RAISE_I, // Software raise pulse
  input wire tsec_pkg::tsec_evt_t SW_LEVEL_I, // Level to raise, 7..15
  input wire tsec_pkg::tsec_map_t LEVEL_MASK_I, // Enables for levels 7..15
  input wire tsec_pkg::tsec_addr_t CUR_PC_I, // Address being interrupted
  input wire logic RETURN_I, // Return-from-event pulse
  input wire tsec_pkg::tsec_evt_t RETURN_NUM_I, // Event being returned from
  output logic TAKE_O, // Event taken pulse
  output tsec_pkg::tsec_evt_t TAKE_NUM_O, // Number of event taken
  output logic SAVE_STATE_O, // Push state to supervisor stack
  output logic RESUME_O, // Return accepted pulse
  output tsec_pkg::tsec_addr_t RESUME_ADDR_O, // Address to resume at
  output logic EMU_MODE_O, // Emulation mode active
  output logic CORE_RESET_O, // Whole processor reset
  output tsec_pkg::tsec_exc_t EXC_CAUSE_O, // Cause of last exception
  output logic NMI_WDOG_O, // Last non-maskable came from watchdog
  output tsec_pkg::tsec_map_t PENDING_O, // Latched pending events
  output tsec_pkg::tsec_map_t ACTIVE_O // Active service routines
);
  import tsec_pkg::*;

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  tsec_core_if link ();

  tsec_sic #(
    .PERIPH_N(PERIPH_N)
  ) u_sic (
    .clk_i(CLK_I),
    .reset_i(RESET_I),
    .ce_i(CE_I),
    .req_i(PERIPH_REQ_I),
    .enable_i(PERIPH_EN_I),
    .level_i(PERIPH_LVL_I),
    .core(link.sic_mp)
  );

  tsec_retbank u_bank (
    .clk_i(CLK_I),
    .reset_i(RESET_I),
    .ce_i(CE_I),
    .core(link.bank_mp)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  tsec_state_t state_reg;
  tsec_state_t state_next;
  tsec_map_t pend_reg;
  tsec_map_t pend_next;
  tsec_map_t act_reg;
  tsec_map_t act_next;
  logic [3:0] hold_reg;
  logic [3:0] hold_next;
  logic take_reg;
  tsec_evt_t take_num_reg;
  logic resume_reg;
  tsec_addr_t resume_addr_reg;
  tsec_exc_t exc_cause_reg;
  logic nmi_wdog_reg;
  logic core_rst_reg;

  // ----------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------
  // Software raise only reaches the general-purpose range
  wire sw_ok = SW_RAISE_I && (SW_LEVEL_I >= `TSEC_GP_FIRST);
  wire tsec_map_t sw_map = sw_ok ? (tsec_map_t'(1) << SW_LEVEL_I) : `TSEC_ZERO_MAP;
  wire nmi_req = NMI_PIN_I | WDOG_NMI_I;
  // Dedicated events as a map, indexed by event number
  wire tsec_map_t ded_map = (tsec_map_t'(EMU_REQ_I) << `TSEC_EVT_EMU) |
                            (tsec_map_t'(RESET_REQ_I) << `TSEC_EVT_RST) |
                            (tsec_map_t'(nmi_req) << `TSEC_EVT_NMI) |
                            (tsec_map_t'(EXC_REQ_I) << `TSEC_EVT_EXC);
  // New arrivals this cycle; peripheral levels come through the system stage
  wire tsec_map_t arrive = ded_map | link.gp_req | sw_map;
  // Only general-purpose levels obey the mask; dedicated events never do
  wire tsec_map_t gp_bits = {{(`TSEC_NUM_EVT - `TSEC_GP_FIRST){1'b1}}, {`TSEC_GP_FIRST{1'b0}}};
  wire tsec_map_t eligible = pend_reg & (~gp_bits | LEVEL_MASK_I);

  // ----------------------------------------------------------------
  // Priority resolution
  // ----------------------------------------------------------------
  // Lowest number first fixes emulation, reset, NMI, exception, then 7..15
  wire logic [4:0] cand = tsec_lowest(eligible);
  wire logic [4:0] cur = tsec_lowest(act_reg);
  // Strictly higher priority than every active routine preempts it
  wire take_ok = (state_reg == TSEC_ST_RUN) && (cand < cur);
  wire tsec_evt_t cand_evt = cand[`TSEC_EVT_W-1:0];
  wire take_rst = take_ok && (cand_evt == `TSEC_EVT_RST);
  // A return counts only for a routine that is really active
  wire ret_ok = RETURN_I && act_reg[RETURN_NUM_I] && (state_reg == TSEC_ST_RUN);
  wire tsec_map_t take_map = take_ok ? (tsec_map_t'(1) << cand_evt) : `TSEC_ZERO_MAP;
  wire tsec_map_t ret_map = ret_ok ? (tsec_map_t'(1) << RETURN_NUM_I) : `TSEC_ZERO_MAP;

  // Bank traffic: write on take, read the returning event
  assign link.wr_en = take_ok;
  assign link.wr_idx = cand_evt;
  assign link.wr_addr = CUR_PC_I;
  assign link.rd_idx = RETURN_NUM_I;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Arrival beats the clear on taking, so nothing is lost
  always_comb begin
    state_next = state_reg;
    hold_next = hold_reg;
    pend_next = (pend_reg & ~take_map) | arrive;
    act_next = (act_reg & ~ret_map) | take_map;
    unique case (state_reg)
      TSEC_ST_RUN: begin
        if (take_rst) begin
          state_next = TSEC_ST_RESET;
          hold_next = RST_HOLD;
        end
      end
      TSEC_ST_RESET: begin
        // Hold the processor reset for a fixed count, ignore returns
        pend_next = pend_reg | arrive;
        act_next = act_reg;
        if (hold_reg == 4'h1) begin
          state_next = TSEC_ST_CLEAR;
        end else begin
          hold_next = hold_reg - 4'h1;
        end
      end
      TSEC_ST_CLEAR: begin
        // Whole processor restarts: drop every routine, keep reset active
        pend_next = arrive & ~(tsec_map_t'(1) << `TSEC_EVT_RST);
        act_next = tsec_map_t'(1) << `TSEC_EVT_RST;
        state_next = TSEC_ST_RUN;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Controller state
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      state_reg <= TSEC_ST_RUN;
      hold_reg <= 4'h0;
      pend_reg <= `TSEC_ZERO_MAP;
      act_reg <= `TSEC_ZERO_MAP;
    end else if (CE_I) begin
      state_reg <= state_next;
      hold_reg <= hold_next;
      pend_reg <= pend_next;
      act_reg <= act_next;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer-facing outputs
  // ----------------------------------------------------------------
  // Take and state save share one pulse, so the push is never skipped
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      take_reg <= 1'b0;
      take_num_reg <= `TSEC_EVT_EMU;
      resume_reg <= 1'b0;
      resume_addr_reg <= '0;
    end else if (CE_I) begin
      take_reg <= take_ok;
      if (take_ok) begin
        take_num_reg <= cand_evt;
      end
      resume_reg <= ret_ok;
      if (ret_ok) begin
        resume_addr_reg <= link.rd_addr;
      end
    end
  end

  // Exception cause and non-maskable source, captured in the cycle the request arrives
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      exc_cause_reg <= TSEC_EXC_ALIGN;
      nmi_wdog_reg <= 1'b0;
    end else if (CE_I) begin
      if (EXC_REQ_I) begin
        exc_cause_reg <= EXC_CAUSE_I;
      end
      if (nmi_req) begin
        nmi_wdog_reg <= WDOG_NMI_I;
      end
    end
  end

  // Processor reset is high in the same cycles as the hold phase
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      core_rst_reg <= 1'b0;
    end else if (CE_I) begin
      core_rst_reg <= (state_next == TSEC_ST_RESET);
    end
  end

  assign TAKE_O = take_reg;
  assign TAKE_NUM_O = take_num_reg;
  assign SAVE_STATE_O = take_reg;
  assign RESUME_O = resume_reg;
  assign RESUME_ADDR_O = resume_addr_reg;
  assign EMU_MODE_O = act_reg[`TSEC_EVT_EMU];
  assign CORE_RESET_O = core_rst_reg;
  assign EXC_CAUSE_O = exc_cause_reg;
  assign NMI_WDOG_O = nmi_wdog_reg;
  assign PENDING_O = pend_reg;
  assign ACTIVE_O = act_reg;
endmodule // tsec_top

// ---- tb/tsec_top_props.sv ----
// Concurrent checks on the event controller's top ports
`timescale 1ns/1ps
module tsec_top_props (
  input wire logic CLK_I, // Core clock
  input wire logic RESET_I, // Sync reset
  input wire logic CE_I, // Clock enable
  input wire logic NMI_PIN_I, // Non-maskable pin
  input wire logic WDOG_NMI_I, // Watchdog request
  input wire logic EXC_REQ_I, // Exception request
  input wire tsec_pkg::tsec_exc_t EXC_CAUSE_I, // Exception cause
  input wire logic RETURN_I, // Return pulse
  input wire tsec_pkg::tsec_evt_t RETURN_NUM_I, // Event returned from
  input wire logic TAKE_O, // Take pulse
  input wire tsec_pkg::tsec_evt_t TAKE_NUM_O, // Event taken
  input wire logic SAVE_STATE_O, // State push
  input wire logic RESUME_O, // Return accepted
  input wire logic EMU_MODE_O, // Emulation mode
  input wire logic CORE_RESET_O, // Processor reset
  input wire tsec_pkg::tsec_exc_t EXC_CAUSE_O, // Last cause
  input wire logic NMI_WDOG_O, // Last source was watchdog
  input wire tsec_pkg::tsec_map_t PENDING_O, // Pending events
  input wire tsec_pkg::tsec_map_t ACTIVE_O // Active routines
);
  import tsec_pkg::*;
  // ----------------------------------------------------------------
  // Properties, one clock domain
  // ----------------------------------------------------------------
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RESET_I);
  a_save_with_take: assert property (SAVE_STATE_O == TAKE_O) else $error("state push differs from take");
  a_emu_tracks: assert property (EMU_MODE_O == ACTIVE_O[0]) else $error("emulation mode wrong");
  a_take_active: assert property (TAKE_O |-> ACTIVE_O[TAKE_NUM_O]) else $error("taken event not active");
  a_take_pending: assert property (TAKE_O |-> ($past(PENDING_O) & (16'h1 << TAKE_NUM_O)) != 16'h0)
    else $error("taken event was not pending");
  // Strictly higher priority than every active routine
  a_preempt_strict: assert property (TAKE_O |-> ($past(ACTIVE_O) & ((16'h2 << TAKE_NUM_O) - 16'h1)) == 16'h0)
    else $error("take did not outrank active");
  a_dedic_order: assert property (TAKE_O |-> ($past(PENDING_O[3:0]) & ((4'h1 << TAKE_NUM_O) - 4'h1)) == 4'h0)
    else $error("higher dedicated event skipped");
  a_reset_hold: assert property (TAKE_O && TAKE_NUM_O == 4'h1 |-> CORE_RESET_O [*4])
    else $error("reset hold too short");
  a_hold_no_take: assert property (CORE_RESET_O && $past(CORE_RESET_O) |-> !TAKE_O)
    else $error("take during reset hold");
  a_nmi_unmasked: assert property (PENDING_O[2] && PENDING_O[1:0] == 2'b00 && ACTIVE_O[2:0] == 3'b000 && CE_I
    && !CORE_RESET_O |=> TAKE_O && TAKE_NUM_O == 4'h2) else $error("non-maskable not taken");
  a_nmi_source: assert property ((NMI_PIN_I || WDOG_NMI_I) && CE_I && !CORE_RESET_O |=> NMI_WDOG_O == $past(WDOG_NMI_I))
    else $error("non-maskable source wrong");
  a_exc_cause: assert property (EXC_REQ_I && CE_I |=> EXC_CAUSE_O == $past(EXC_CAUSE_I))
    else $error("exception cause wrong");
  a_return_resumes: assert property (RETURN_I && CE_I && !CORE_RESET_O && ACTIVE_O[RETURN_NUM_I]
    |=> RESUME_O && !ACTIVE_O[$past(RETURN_NUM_I)]) else $error("return not honoured");
  a_resume_cause: assert property (RESUME_O |-> $past(RETURN_I)) else $error("resume without return");
  // A low clock enable must hold the pending, active and take outputs
  a_ce_freeze: assert property (!CE_I |=> $stable(PENDING_O) && $stable(ACTIVE_O) && $stable(TAKE_O))
    else $error("state moved with clock enable low");
  // Main scenarios reached
  c_nested: cover property (TAKE_O && TAKE_NUM_O == 4'h2 && ACTIVE_O[9]);
  c_reset_evt: cover property ($rose(CORE_RESET_O));
  c_resume: cover property (RESUME_O);
endmodule // tsec_top_props

bind tsec_top tsec_top_props i_props (.CLK_I(CLK_I), .RESET_I(RESET_I), .CE_I(CE_I), .NMI_PIN_I(NMI_PIN_I),
  .WDOG_NMI_I(WDOG_NMI_I), .EXC_REQ_I(EXC_REQ_I), .EXC_CAUSE_I(EXC_CAUSE_I), .RETURN_I(RETURN_I),
  .RETURN_NUM_I(RETURN_NUM_I), .TAKE_O(TAKE_O), .TAKE_NUM_O(TAKE_NUM_O), .SAVE_STATE_O(SAVE_STATE_O),
  .RESUME_O(RESUME_O), .EMU_MODE_O(EMU_MODE_O), .CORE_RESET_O(CORE_RESET_O), .EXC_CAUSE_O(EXC_CAUSE_O),
  .NMI_WDOG_O(NMI_WDOG_O), .PENDING_O(PENDING_O), .ACTIVE_O(ACTIVE_O));

// ---- tb/tsec_seq_model.sv ----
// Sequencer model: program counter, saved addresses and returns
`timescale 1ns/1ps
module tsec_seq_model (
  input wire logic clk_i, // Core clock
  input wire logic take_i, // Take pulse from controller
  input wire tsec_pkg::tsec_evt_t take_num_i, // Event taken
  input wire logic go_i, // Bench asks for a return
  input wire tsec_pkg::tsec_evt_t num_i, // Event to return from
  input wire logic [3:0] lag_i, // Handler length in cycles
  output tsec_pkg::tsec_addr_t pc_o, // Current program address
  output logic ret_o, // Return pulse
  output tsec_pkg::tsec_evt_t ret_num_o // Number with the return
);
  import tsec_pkg::*;
  tsec_addr_t saved [16];
  tsec_addr_t pc_s;
  logic [4:0] cnt;
  initial begin
    pc_o = 32'h00001000;
    ret_o = 1'b0;
    ret_num_o = 4'h0;
    cnt = 5'h0;
  end
  // Address the controller sees at each edge
  always @(posedge clk_i) pc_s <= pc_o;
  // Program flow never waits for events, so the address moves every cycle
  always @(negedge clk_i) begin
    pc_o <= pc_o + 32'h4;
    if (take_i) saved[take_num_i] <= pc_s;
    ret_o <= 1'b0;
    ret_num_o <= ~ret_num_o; // Number is junk outside a return
    if (go_i) begin
      cnt <= {1'b0, lag_i} + 5'h1;
    end else if (cnt == 5'h1) begin
      ret_o <= 1'b1;
      ret_num_o <= num_i;
      cnt <= 5'h0;
    end else if (cnt != 5'h0) begin
      cnt <= cnt - 5'h1;
    end
  end
endmodule // tsec_seq_model

// ---- tb/test_two_stage_event_controller.sv ----
// Self-checking bench for the two-stage event controller
`timescale 1ns/1ps
module test_two_stage_event_controller;
  import tsec_pkg::*;
  logic clk, rst, ce, emu, rreq, nmi_pin, wdog, exc, sw, go, ret;
  logic take, save, resume, emu_mode, core_rst, nmi_w;
  logic [3:0] lag;
  logic [15:0] preq, pen;
  logic [47:0] plvl;
  tsec_exc_t cause, cause_o;
  tsec_evt_t sw_lvl, num, ret_num, take_num;
  tsec_map_t mask, pend, act;
  tsec_addr_t pc, raddr;
  int n_fail, n_compared;
  // ----------------------------------------------------------------
  // Device and sequencer model
  // ----------------------------------------------------------------
  tsec_top #(.PERIPH_N(16), .RST_HOLD(4'h4)) i_dut (.CLK_I(clk), .RESET_I(rst), .CE_I(ce), .EMU_REQ_I(emu),
    .RESET_REQ_I(rreq), .NMI_PIN_I(nmi_pin), .WDOG_NMI_I(wdog), .EXC_REQ_I(exc), .EXC_CAUSE_I(cause),
    .PERIPH_REQ_I(preq), .PERIPH_EN_I(pen), .PERIPH_LVL_I(plvl), .SW_RAISE_I(sw), .SW_LEVEL_I(sw_lvl),
    .LEVEL_MASK_I(mask), .CUR_PC_I(pc), .RETURN_I(ret), .RETURN_NUM_I(ret_num), .TAKE_O(take),
    .TAKE_NUM_O(take_num), .SAVE_STATE_O(save), .RESUME_O(resume), .RESUME_ADDR_O(raddr), .EMU_MODE_O(emu_mode),
    .CORE_RESET_O(core_rst), .EXC_CAUSE_O(cause_o), .NMI_WDOG_O(nmi_w), .PENDING_O(pend), .ACTIVE_O(act));
  tsec_seq_model i_seq (.clk_i(clk), .take_i(take), .take_num_i(take_num), .go_i(go), .num_i(num), .lag_i(lag),
    .pc_o(pc), .ret_o(ret), .ret_num_o(ret_num));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Bounded wait for a take, then its number
  task automatic take_of(input tsec_evt_t n);
    int k;
    k = 0;
    while (take !== 1'b1 && k < 12) begin
      @(negedge clk);
      k++;
    end
    chk(32'(k < 12), 32'h1);
    chk(32'(take_num), 32'(n));
    chk(32'(save), 32'h1);
  endtask
  task automatic quiet(input int n);
    repeat (n) begin
      @(negedge clk);
      chk(32'(take), 32'h0);
    end
  endtask
  // Model returns after a lag; resume must carry the saved address
  task automatic ret_of(input tsec_evt_t n, input logic [3:0] l);
    int k;
    go <= 1'b1;
    num <= n;
    lag <= l;
    @(negedge clk);
    go <= 1'b0;
    k = 0;
    while (resume !== 1'b1 && k < 24) begin
      @(negedge clk);
      k++;
    end
    chk(32'(k < 24), 32'h1);
    chk(raddr, i_seq.saved[n]);
    chk(32'(act[n]), 32'h0);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic s_emu;
    @(negedge clk) emu = 1'b1;
    @(negedge clk) emu = 1'b0;
    take_of(4'h0);
    chk(32'(emu_mode), 32'h1);
    ret_of(4'h0, 4'h1);
    chk(32'(emu_mode), 32'h0);
  endtask
  task automatic s_exc;
    for (int i = 0; i < 2; i++) begin
      @(negedge clk);
      exc = 1'b1;
      cause = tsec_exc_t'(i);
      @(negedge clk) exc = 1'b0;
      take_of(4'h3);
      chk(32'(cause_o), 32'(i));
      ret_of(4'h3, 4'(i * 9));
    end
  endtask
  // Both sources with every level masked off
  task automatic s_nmi;
    mask = 16'h0000;
    for (int i = 0; i < 2; i++) begin
      @(negedge clk);
      nmi_pin = (i == 0);
      wdog = (i == 1);
      @(negedge clk);
      nmi_pin = 1'b0;
      wdog = 1'b0;
      take_of(4'h2);
      chk(32'(nmi_w), 32'(i));
      ret_of(4'h2, 4'h0);
    end
    mask = 16'hff80;
  endtask
  // Simultaneous requests, waiting level, then nesting under a level
  task automatic s_prio;
    @(negedge clk);
    exc = 1'b1;
    sw = 1'b1;
    sw_lvl = 4'h9;
    @(negedge clk);
    exc = 1'b0;
    sw = 1'b0;
    take_of(4'h3);
    quiet(3);
    chk(32'(pend[9]), 32'h1);
    ret_of(4'h3, 4'h2);
    take_of(4'h9);
    @(negedge clk) nmi_pin = 1'b1;
    @(negedge clk) nmi_pin = 1'b0;
    take_of(4'h2);
    chk(act, 32'h0204);
    ret_of(4'h2, 4'h1);
    ret_of(4'h9, 4'h0);
  endtask
  // Sources 3, 7, 11 at offsets 0, 3, 6; then dropped, disabled, masked
  task automatic s_periph;
    for (int i = 0; i < 3; i++) begin
      @(negedge clk);
      plvl[3 * (3 + 4 * i) +: 3] = 3'(3 * i);
      preq[3 + 4 * i] = 1'b1;
      @(negedge clk) preq = 16'h0000;
      take_of(4'(7 + 3 * i));
      ret_of(4'(7 + 3 * i), 4'(i));
    end
    @(negedge clk);
    plvl[2:0] = 3'h7;
    pen[1] = 1'b0;
    preq = 16'h0003;
    @(negedge clk) preq = 16'h0000;
    quiet(4);
    chk(pend, 32'h0);
    pen = 16'hffff;
    mask[7] = 1'b0;
    preq[3] = 1'b1;
    @(negedge clk) preq = 16'h0000;
    quiet(4);
    chk(32'(pend[7]), 32'h1);
    mask[7] = 1'b1;
    take_of(4'h7);
    ret_of(4'h7, 4'h3);
  endtask
  // Software raise of levels 14 and 15; number 5, below the general-purpose range, is ignored
  task automatic s_sw;
    for (int i = 0; i < 3; i++) begin
      @(negedge clk);
      sw = 1'b1;
      sw_lvl = (i == 2) ? 4'h5 : 4'(14 + i);
      @(negedge clk) sw = 1'b0;
      if (i < 2) begin
        take_of(4'(14 + i));
        ret_of(4'(14 + i), 4'h0);
      end else begin
        quiet(4);
        chk(pend, 32'h0);
      end
    end
  endtask
  task automatic s_rst;
    int k;
    @(negedge clk) rreq = 1'b1;
    @(negedge clk) rreq = 1'b0;
    take_of(4'h1);
    k = 0;
    while (core_rst === 1'b1 && k < 20) begin
      @(negedge clk);
      k++;
    end
    chk(32'(k), 32'h4);
    chk(act, 32'h0002);
    ret_of(4'h1, 4'h0);
  endtask
  // Clock enable low freezes everything; a raise seen only while frozen is lost
  task automatic s_ce;
    @(negedge clk);
    ce = 1'b0;
    exc = 1'b1;
    sw = 1'b1;
    sw_lvl = 4'h8;
    quiet(3);
    chk(pend, 32'h0);
    ce = 1'b1;
    sw = 1'b0;
    @(negedge clk) exc = 1'b0;
    take_of(4'h3);
    chk(pend, 32'h0);
    ret_of(4'h3, 4'h0);
  endtask
  // ----------------------------------------------------------------
  // Clock, reset, sequence and verdict
  // ----------------------------------------------------------------
  task automatic wrap_up;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    {rst, emu, rreq, nmi_pin, wdog, exc, sw, go} = 8'h80;
    ce = 1'b1;
    cause = TSEC_EXC_ALIGN;
    {sw_lvl, num, lag, preq, plvl} = '0;
    pen = 16'hffff;
    mask = 16'hff80;
    n_fail = 0;
    n_compared = 0;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    s_emu();
    s_exc();
    s_nmi();
    s_prio();
    s_periph();
    s_sw();
    s_ce();
    s_rst();
    wrap_up();
  end
endmodule // test_two_stage_event_controller
